// *** core/iommu_req_pkg.sv ***
// Functional notes
// R1 - head: type plus 3 reserved; tail: status plus 3
// R2 - status codes zero through eight as listed
// R3 - type codes: attach 1 through probe 5
// R4 - request posted, returned with status filled
// R5 - unparsable request returned with nothing written
// R6 - lowest page mask bit sets granularity
// R7 - domain range limits ids when offered
// R8 - input range limits mappings, else full 64-bit
// R9 - bypass: config bypass, bypass domain, legacy bypass
// R10 - bypass accesses allowed, identity translated
// R11 - driver zeroes head reserved, ignores tail reserved
// R12 - zero used length means failed request
// R13 - driver keeps addresses and domains in range
// R14 - success status written on success
// R15 - unknown type: nothing written, length zero
// R16 - head reserved ignored, tail reserved zeroed
// R17 - unattached non-bypass endpoints are blocked
// R18 - attach layout: domain, endpoint, flags, reserved
// R19 - domain ids unique; attach creates domain
// R20 - endpoint ids distinct, one slot each
// R21 - endpoint in one domain; domains isolated
// R22 - bypass flag creates bypass domain
// R23 - driver sets bypass flag consistently
// R24 - driver groups non-isolable endpoints, zero reserved
// R25 - reset leaves no endpoint attached
// R26 - config bypass field shows only 0 or 1
package iommu_req_pkg;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_FEAT     = 12'h004;
  localparam logic [11:0] ADDR_BYPASS   = 12'h008;
  localparam logic [11:0] ADDR_DOM_LO   = 12'h00C;
  localparam logic [11:0] ADDR_DOM_HI   = 12'h010;
  localparam logic [11:0] ADDR_REQ_HEAD = 12'h014;
  localparam logic [11:0] ADDR_REQ_DOM  = 12'h018;
  localparam logic [11:0] ADDR_REQ_EP   = 12'h01C;
  localparam logic [11:0] ADDR_REQ_FLG  = 12'h020;
  localparam logic [11:0] ADDR_REQ_RSV  = 12'h024;
  localparam logic [11:0] ADDR_REQ_LEN  = 12'h028;
  localparam logic [11:0] ADDR_RESP     = 12'h02C;
  localparam logic [11:0] ADDR_PGMASK   = 12'h030;
  localparam logic [11:0] ADDR_XL_EP    = 12'h034;
  localparam logic [11:0] ADDR_XL_RES   = 12'h038;
  localparam int FEAT_INPUT_RANGE  = 0;
  localparam int FEAT_DOMAIN_RANGE = 1;
  localparam int FEAT_BYPASS       = 3;
  localparam int FEAT_BYPASS_CFG   = 6;
  localparam logic [7:0] T_ATTACH = 8'h01;
  localparam logic [7:0] T_DETACH = 8'h02;
  localparam logic [7:0] T_MAP    = 8'h03;
  localparam logic [7:0] T_UNMAP  = 8'h04;
  localparam logic [7:0] T_PROBE  = 8'h05;
  localparam logic [7:0] S_OK     = 8'h00;
  localparam logic [7:0] S_IOERR  = 8'h01;
  localparam logic [7:0] S_UNSUPP = 8'h02;
  localparam logic [7:0] S_DEVERR = 8'h03;
  localparam logic [7:0] S_INVAL  = 8'h04;
  localparam logic [7:0] S_RANGE  = 8'h05;
  localparam logic [7:0] S_NOENT  = 8'h06;
  localparam logic [7:0] S_FAULT  = 8'h07;
  localparam logic [7:0] S_NOMEM  = 8'h08;
  localparam logic [31:0] ATTACH_LEN   = 32'h00000014;
  localparam logic [31:0] TAIL_LEN     = 32'h00000004;
  localparam int          ATTACH_F_BYP = 0;
  localparam logic [7:0]  BYPASS_RST   = 8'h00;
  localparam logic [63:0] PGMASK_RST   = 64'h0000000000001000;
endpackage

// *** core/iommu_request_processing.sv ***
`timescale 1ns/1ps
module iommu_request_processing
#(
  parameter int EP_COUNT  = 8,
  parameter int DOM_SLOTS = 4
)(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // completion
  output logic             req_done,
  // access check
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_ep,
  input  wire logic [63:0] acc_addr,
  output logic             acc_allow,
  output logic             acc_bypass,
  output logic [63:0]      acc_out_addr
);
  import iommu_req_pkg::*;

  localparam int EPW = $clog2(EP_COUNT);
  localparam int DSW = $clog2(DOM_SLOTS);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] feat_reg;
  logic [7:0]  bypass_reg;
  logic [31:0] dom_lo_reg, dom_hi_reg;
  logic [31:0] head_reg, rdom_reg, rep_reg, rflg_reg, rrsv_reg, rlen_reg;
  logic [31:0] resp_reg;
  logic [31:0] xl_ep_reg;
  logic        done_reg;
  logic [EP_COUNT-1:0]  ep_att_reg;
  logic [DSW-1:0]       ep_slot_reg [EP_COUNT];
  logic [DOM_SLOTS-1:0] dom_used_reg;
  logic [DOM_SLOTS-1:0] dom_byp_reg;
  logic [31:0]          dom_id_reg [DOM_SLOTS];

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // endpoint slot lookup: the id selects exactly one slot
  function automatic logic ep_ok(input logic [31:0] ep);
    ep_ok = ep < 32'(EP_COUNT); // R20
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_XL_RES);
  wire go = wr_en && (paddr == ADDR_CTRL) && pwdata[0];
  wire [7:0] req_type = head_reg[7:0]; // R1 R16
  wire dom_chk = !feat_reg[FEAT_DOMAIN_RANGE] || in_range(rdom_reg, dom_lo_reg, dom_hi_reg); // R7
  wire [EPW-1:0] rep_idx = rep_reg[EPW-1:0];
  wire want_byp = rflg_reg[ATTACH_F_BYP]; // R18

  logic [DOM_SLOTS-1:0] hit_vec;
  logic                 free_ok;
  logic [DSW-1:0]       hit_idx, free_idx;
  always_comb
  begin
    hit_idx  = '0;
    free_idx = '0;
    free_ok  = 1'b0;
    for (int i = 0; i < DOM_SLOTS; i++)
    begin
      hit_vec[i] = dom_used_reg[i] && (dom_id_reg[i] == rdom_reg); // R19
      if (hit_vec[i])
        hit_idx = DSW'(i);
    end
    for (int i = DOM_SLOTS - 1; i >= 0; i--)
    begin
      if (!dom_used_reg[i])
      begin
        free_ok  = 1'b1;
        free_idx = DSW'(i);
      end
    end
  end
  wire dom_hit = |hit_vec;
  wire [DSW-1:0] tgt_idx = dom_hit ? hit_idx : free_idx;

  // attach outcome
  logic [7:0] att_status;
  always_comb
  begin
    if (rrsv_reg != 32'h0 || rflg_reg[31:1] != 31'h0)
      att_status = S_INVAL;
    else if (!dom_chk)
      att_status = S_RANGE;
    else if (!ep_ok(rep_reg))
      att_status = S_NOENT;
    else if (want_byp && !feat_reg[FEAT_BYPASS_CFG])
      att_status = S_INVAL; // R22
    else if (dom_hit && (dom_byp_reg[hit_idx] != want_byp))
      att_status = S_INVAL;
    else if (!dom_hit && !free_ok)
      att_status = S_NOMEM;
    else
      att_status = S_OK; // R14
  end

  // unparsable or unknown: no write, zero used length
  wire too_short = rlen_reg < TAIL_LEN + 32'h4 || (req_type == T_ATTACH && rlen_reg < ATTACH_LEN); // R5
  wire known = (req_type == T_ATTACH); // R3 R15
  wire do_att = go && !too_short && known && att_status == S_OK;

  // used length in [31:8], status in [7:0]
  wire [31:0] resp_next = (too_short || !known) ? 32'h0 :
                          {rlen_reg[23:0], att_status}; // R4 R16

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      feat_reg   <= '0;
      bypass_reg <= BYPASS_RST;
      dom_lo_reg <= '0;
      dom_hi_reg <= '1;
      head_reg   <= '0;
      rdom_reg   <= '0;
      rep_reg    <= '0;
      rflg_reg   <= '0;
      rrsv_reg   <= '0;
      rlen_reg   <= '0;
      xl_ep_reg  <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_FEAT:     feat_reg   <= pwdata;
        ADDR_BYPASS:   bypass_reg <= {7'h0, pwdata[0]}; // R26
        ADDR_DOM_LO:   dom_lo_reg <= pwdata;
        ADDR_DOM_HI:   dom_hi_reg <= pwdata;
        ADDR_REQ_HEAD: head_reg   <= pwdata;
        ADDR_REQ_DOM:  rdom_reg   <= pwdata;
        ADDR_REQ_EP:   rep_reg    <= pwdata;
        ADDR_REQ_FLG:  rflg_reg   <= pwdata;
        ADDR_REQ_RSV:  rrsv_reg   <= pwdata;
        ADDR_REQ_LEN:  rlen_reg   <= pwdata;
        ADDR_XL_EP:    xl_ep_reg  <= pwdata;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resp_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= go;
      if (go)
        resp_reg <= resp_next;
    end
  end

  // attach table; moving an endpoint detaches it from its old domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ep_att_reg   <= '0; // R25
      dom_used_reg <= '0;
      dom_byp_reg  <= '0;
      for (int i = 0; i < EP_COUNT; i++)
        ep_slot_reg[i] <= '0;
      for (int i = 0; i < DOM_SLOTS; i++)
        dom_id_reg[i] <= '0;
    end
    else if (do_att)
    begin
      ep_att_reg[rep_idx] <= 1'b1; // R21
      if (dom_hit)
        ep_slot_reg[rep_idx] <= hit_idx;
      else
      begin
        ep_slot_reg[rep_idx]   <= free_idx; // R19
        dom_used_reg[free_idx] <= 1'b1;
        dom_byp_reg[free_idx]  <= want_byp; // R22
        dom_id_reg[free_idx]   <= rdom_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access path; mapping tables live outside, so attached non-bypass is refused here
  wire [EPW-1:0] a_idx = acc_ep[EPW-1:0];
  wire a_att = ep_ok(acc_ep) && ep_att_reg[a_idx];
  wire a_byp = ep_ok(acc_ep) &&
               ((feat_reg[FEAT_BYPASS_CFG] && bypass_reg[0] && !a_att) ||
                (a_att && dom_byp_reg[ep_slot_reg[a_idx]]) ||
                (feat_reg[FEAT_BYPASS] && !a_att)); // R9
  wire a_allow = acc_valid && a_byp; // R10 R17

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_allow    <= 1'b0;
      acc_bypass   <= 1'b0;
      acc_out_addr <= '0;
    end
    else
    begin
      acc_allow    <= a_allow;
      acc_bypass   <= acc_valid && a_byp;
      acc_out_addr <= a_allow ? acc_addr : 64'h0; // R8 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  wire [EPW-1:0] x_idx = xl_ep_reg[EPW-1:0];
  wire x_att = ep_ok(xl_ep_reg) && ep_att_reg[x_idx];
  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      ADDR_FEAT:     rd_mux = feat_reg;
      ADDR_BYPASS:   rd_mux = {24'h0, bypass_reg}; // R26
      ADDR_DOM_LO:   rd_mux = dom_lo_reg;
      ADDR_DOM_HI:   rd_mux = dom_hi_reg;
      ADDR_REQ_HEAD: rd_mux = head_reg;
      ADDR_REQ_DOM:  rd_mux = rdom_reg;
      ADDR_REQ_EP:   rd_mux = rep_reg;
      ADDR_REQ_FLG:  rd_mux = rflg_reg;
      ADDR_REQ_RSV:  rd_mux = rrsv_reg;
      ADDR_REQ_LEN:  rd_mux = rlen_reg;
      ADDR_RESP:     rd_mux = resp_reg;
      ADDR_PGMASK:   rd_mux = PGMASK_RST[31:0]; // R6
      ADDR_XL_EP:    rd_mux = xl_ep_reg;
      ADDR_XL_RES:   rd_mux = {30'h0, x_att, dom_byp_reg[ep_slot_reg[x_idx]] & x_att};
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign req_done = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_unknown_silent;
    @(posedge pclk) disable iff (!presetn)
    (go && !known) |=> (resp_reg == 32'h0 && done_reg);
  endproperty
  a_unknown_silent: assert property (p_unknown_silent) else $error("unknown type wrote response"); // R15

  property p_short_silent;
    @(posedge pclk) disable iff (!presetn)
    (go && too_short) |=> (resp_reg == 32'h0);
  endproperty
  a_short_silent: assert property (p_short_silent) else $error("short request wrote response"); // R5

  property p_ok_attaches;
    @(posedge pclk) disable iff (!presetn)
    do_att |=> ep_att_reg[$past(rep_idx)] && resp_reg[7:0] == S_OK;
  endproperty
  a_ok_attaches: assert property (p_ok_attaches) else $error("attach not recorded"); // R14

  property p_status_range;
    @(posedge pclk) disable iff (!presetn)
    done_reg |-> resp_reg[7:0] <= S_NOMEM;
  endproperty
  a_status_range: assert property (p_status_range) else $error("status code out of set"); // R2

  property p_bypass_field;
    @(posedge pclk) disable iff (!presetn)
    bypass_reg[7:1] == 7'h0;
  endproperty
  a_bypass_field: assert property (p_bypass_field) else $error("bypass field not 0 or 1"); // R26

  property p_block_unatt;
    @(posedge pclk) disable iff (!presetn)
    (acc_valid && !a_byp) |=> !acc_allow;
  endproperty
  a_block_unatt: assert property (p_block_unatt) else $error("non-bypass access allowed"); // R17

  property p_identity;
    @(posedge pclk) disable iff (!presetn)
    (acc_valid && a_byp) |=> acc_allow && acc_out_addr == $past(acc_addr);
  endproperty
  a_identity: assert property (p_identity) else $error("bypass not identity"); // R10

  property p_dom_range;
    @(posedge pclk) disable iff (!presetn)
    (go && known && feat_reg[FEAT_DOMAIN_RANGE] && !in_range(rdom_reg, dom_lo_reg, dom_hi_reg)) |=> !$past(do_att);
  endproperty
  a_dom_range: assert property (p_dom_range) else $error("out of range domain attached"); // R7

  property p_done_pulse;
    @(posedge pclk) disable iff (!presetn)
    go |=> done_reg;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("request not returned"); // R4

  property p_done_only;
    @(posedge pclk) disable iff (!presetn)
    done_reg |-> $past(go);
  endproperty
  a_done_only: assert property (p_done_only) else $error("completion without request"); // R4

  // software may poll the response at any time between requests
  property p_resp_hold;
    @(posedge pclk) disable iff (!presetn)
    !go |=> $stable(resp_reg);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response changed without request"); // R4

  property p_resv_inval;
    @(posedge pclk) disable iff (!presetn)
    (go && known && !too_short && rrsv_reg != 32'h0) |=> resp_reg[7:0] == S_INVAL;
  endproperty
  a_resv_inval: assert property (p_resv_inval) else $error("reserved word not refused"); // R18

  property p_noent;
    @(posedge pclk) disable iff (!presetn)
    (go && known && !too_short && rrsv_reg == 32'h0 && rflg_reg[31:1] == 31'h0 && dom_chk && !ep_ok(rep_reg))
      |=> resp_reg[7:0] == S_NOENT;
  endproperty
  a_noent: assert property (p_noent) else $error("missing endpoint not reported"); // R20

  // no disable here: the table must be empty while reset is held
  property p_reset_clear;
    @(posedge pclk)
    !presetn |-> (ep_att_reg == '0 && dom_used_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("attachment survived reset"); // R25

  property p_byp_dom_mode;
    @(posedge pclk) disable iff (!presetn)
    (acc_valid && a_att && dom_byp_reg[ep_slot_reg[a_idx]]) |=> acc_bypass && acc_allow;
  endproperty
  a_byp_dom_mode: assert property (p_byp_dom_mode) else $error("bypass domain member not in bypass"); // R22

  property p_att_move;
    @(posedge pclk) disable iff (!presetn)
    do_att |=> ep_slot_reg[$past(rep_idx)] == $past(tgt_idx);
  endproperty
  a_att_move: assert property (p_att_move) else $error("endpoint not moved to domain"); // R21

  property p_new_dom;
    @(posedge pclk) disable iff (!presetn)
    (do_att && !dom_hit) |=> dom_used_reg[$past(free_idx)] && dom_id_reg[$past(free_idx)] == $past(rdom_reg);
  endproperty
  a_new_dom: assert property (p_new_dom) else $error("domain not created"); // R19

  property p_out_zero;
    @(posedge pclk) disable iff (!presetn)
    (acc_valid && !a_byp) |=> acc_out_addr == 64'h0;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("blocked access leaked address"); // R17

  property p_cfg_needed;
    @(posedge pclk) disable iff (!presetn)
    (go && known && !too_short && want_byp && !feat_reg[FEAT_BYPASS_CFG]) |=> resp_reg[7:0] != S_OK;
  endproperty
  a_cfg_needed: assert property (p_cfg_needed) else $error("bypass domain without feature"); // R22
endmodule

// *** sim/guest_driver_model.sv ***
`timescale 1ns/1ps
module guest_driver_model
(
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // completion
  input  wire logic        req_done
);
  import iommu_req_pkg::*;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////
  // request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      iommu_request_processing_tb_top.fail_count++;
      iommu_request_processing_tb_top.stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // caller keeps ids in range and reserved words zero unless testing
  task automatic post(input logic [31:0] head, dom, ep, flg, rsv, len, output logic [31:0] resp);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    xfer(1'b1, ADDR_REQ_HEAD, head, q, e);
    xfer(1'b1, ADDR_REQ_DOM, dom, q, e);
    xfer(1'b1, ADDR_REQ_EP, ep, q, e);
    xfer(1'b1, ADDR_REQ_FLG, flg, q, e);
    xfer(1'b1, ADDR_REQ_RSV, rsv, q, e);
    xfer(1'b1, ADDR_REQ_LEN, len, q, e);
    xfer(1'b1, ADDR_CTRL, 32'h00000001, q, e);
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (req_done !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      iommu_request_processing_tb_top.fail_count++;
      iommu_request_processing_tb_top.stop_test();
    end
    xfer(1'b0, ADDR_RESP, 32'h00000000, resp, e);
  endtask
endmodule

// *** sim/iommu_request_processing_tb_top.sv ***
`timescale 1ns/1ps
module iommu_request_processing_tb_top;
  import iommu_req_pkg::*;
  localparam logic [31:0] HA = {24'h000000, T_ATTACH};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, req_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_ep;
  logic        acc_valid, acc_allow, acc_bypass;
  logic [63:0] acc_addr, acc_out_addr;
  int          fail_count, comparisons;
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  iommu_request_processing DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_done(req_done),
    .acc_valid(acc_valid), .acc_ep(acc_ep), .acc_addr(acc_addr), .acc_allow(acc_allow),
    .acc_bypass(acc_bypass), .acc_out_addr(acc_out_addr));
  guest_driver_model DRV (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_done(req_done));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    DRV.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
    DRV.xfer(1'b0, a, 32'h00000000, q, e);
    chk("rdata", {32'h0, exp}, {32'h0, q});
    chk("pslverr", {63'h0, exp_err}, {63'h0, e});
  endtask
  task automatic att(input logic [31:0] head, dom, ep, flg, rsv, input logic [7:0] st);
    logic [31:0] r;
    DRV.post(head, dom, ep, flg, rsv, ATTACH_LEN, r);
    chk("attach resp", {32'h0, ATTACH_LEN[23:0], st}, {32'h0, r});
  endtask
  // bypass is the only path that grants here
  task automatic acc(input logic [31:0] ep, input logic alw);
    acc_valid <= 1'b1;
    acc_ep <= ep;
    acc_addr <= 64'h123456789ABCDEF0;
    repeat (2) @(posedge pclk);
    chk("allow", {63'h0, alw}, {63'h0, acc_allow});
    chk("bypass", {63'h0, alw}, {63'h0, acc_bypass});
    chk("out addr", alw ? 64'h123456789ABCDEF0 : 64'h0, acc_out_addr);
    acc_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic xl(input logic [31:0] ep, input logic [31:0] exp);
    wr(ADDR_XL_EP, ep);
    rd(ADDR_XL_RES, exp, 1'b0);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    rd(ADDR_PGMASK, PGMASK_RST[31:0], 1'b0);
    rd(ADDR_BYPASS, {24'h0, BYPASS_RST}, 1'b0);
    xl(32'h3, 32'h0);
    rd(12'hFFC, 32'h0, 1'b1);
  endtask
  task automatic t_unknown();
    logic [7:0]  ty [6] = '{T_DETACH, T_MAP, T_UNMAP, T_PROBE, 8'h00, 8'hFF};
    logic [31:0] r;
    foreach (ty[i])
    begin
      DRV.post({24'h0, ty[i]}, 32'h1, 32'h1, 32'h0, 32'h0, ATTACH_LEN, r);
      chk("unknown resp", 64'h0, {32'h0, r});
    end
    DRV.post(HA, 32'h1, 32'h1, 32'h0, 32'h0, 32'h00000010, r);
    chk("short resp", 64'h0, {32'h0, r});
  endtask
  task automatic t_attach();
    att(HA, 32'h1, 32'h3, 32'h0, 32'h0, S_OK);
    xl(32'h3, 32'h2);
    acc(32'h3, 1'b0);
    att({24'hA5A5A5, T_ATTACH}, 32'h2, 32'h3, 32'h0, 32'h0, S_OK);
    att(HA, 32'h1, 32'h4, 32'h0, 32'h1, S_INVAL);
    att(HA, 32'h1, 32'h4, 32'h2, 32'h0, S_INVAL);
    att(HA, 32'h1, 32'h8, 32'h0, 32'h0, S_NOENT);
    att(HA, 32'h9, 32'h4, 32'h1, 32'h0, S_INVAL);
    att(HA, 32'hFFFFFFFF, 32'h4, 32'h0, 32'h0, S_OK);
    wr(ADDR_FEAT, 32'h1 << FEAT_DOMAIN_RANGE);
    wr(ADDR_DOM_LO, 32'h1);
    wr(ADDR_DOM_HI, 32'h2);
    att(HA, 32'h5, 32'h4, 32'h0, 32'h0, S_RANGE);
    att(HA, 32'h2, 32'h4, 32'h0, 32'h0, S_OK);
  endtask
  task automatic t_bypass();
    wr(ADDR_FEAT, 32'h1 << FEAT_BYPASS_CFG);
    wr(ADDR_BYPASS, 32'h000000FF);
    rd(ADDR_BYPASS, 32'h1, 1'b0);
    acc(32'h5, 1'b1);
    att(HA, 32'h7, 32'h6, 32'h1, 32'h0, S_OK);
    xl(32'h6, 32'h3);
    att(HA, 32'h7, 32'h5, 32'h0, 32'h0, S_INVAL);
    wr(ADDR_BYPASS, 32'h0);
    acc(32'h6, 1'b1);
    acc(32'h5, 1'b0);
    wr(ADDR_FEAT, 32'h1 << FEAT_BYPASS);
    acc(32'h5, 1'b1);
    att(HA, 32'h8, 32'h5, 32'h0, 32'h0, S_NOMEM);
    do_reset();
    xl(32'h6, 32'h0);
    acc(32'h6, 1'b0);
    att(HA, 32'h8, 32'h5, 32'h0, 32'h0, S_OK);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    acc_valid = 1'b0;
    acc_ep = 32'h0;
    acc_addr = 64'h0;
    do_reset();
    t_reset_state();
    t_unknown();
    t_attach();
    t_bypass();
    stop_test();
  end
endmodule
